// File: bus_mode_monitor.sv
/* Port checker of the bus mode control block.
   Assumes it is bound onto the design top module, one clock domain. */
`timescale 1ns/100ps
module bus_mode_monitor (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // Requests and chip state
    input wire logic REQ_VALID,
    input wire bus_mode_pkg::reg_req_t REQ,
    input wire bus_mode_pkg::chip_mode_t CHIP_MODE,
    input wire logic FAILURE_ENTRY,
    input wire logic SYSTEM_ERROR_FLAG,
    // Block outputs
    input wire logic [7:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic ACCESS_FAIL,
    input wire bus_mode_pkg::xcvr_ctrl_t XCVR_CTRL
);
    logic [2:0] swk_hist_reg;
    bus_mode_pkg::chip_mode_t mode_reg;
    logic [1:0] can;
    logic sleep_in;
    logic stop_in;
    logic fs_ev;
    logic rd_req;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);
    ////////////////////////////////////////
    // Mode entry and fail-safe events
    assign can = XCVR_CTRL.can_mode;
    assign sleep_in = CHIP_MODE == bus_mode_pkg::CHIP_SLEEP && mode_reg != bus_mode_pkg::CHIP_SLEEP;
    assign stop_in = CHIP_MODE == bus_mode_pkg::CHIP_STOP && mode_reg != bus_mode_pkg::CHIP_STOP;
    assign fs_ev = CHIP_MODE == bus_mode_pkg::CHIP_FAILSAFE && FAILURE_ENTRY;
    assign rd_req = REQ_VALID && !REQ.wr;
    // Previous chip mode, to spot the first cycle of a new mode
    always_ff @(posedge CORE_CLK) begin
        mode_reg <= CHIP_MODE;
    end
    // Causes of a selective-wake change; outputs lag them by two or three edges
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            swk_hist_reg <= 3'h0;
        end else begin
            swk_hist_reg <= {swk_hist_reg[1:0], fs_ev || (REQ_VALID && REQ.wr && REQ.addr == 7'h04)};
        end
    end
    ////////////////////////////////////////
    rd_mapped_a: assert property (rd_req && REQ.addr[6:1] == 6'h02 |=> RD_VALID)
        else $error("mapped read gave no data");
    rd_unmapped_a: assert property (rd_req && REQ.addr[6:1] != 6'h02 |=> !RD_VALID)
        else $error("unmapped read gave data");
    sec_reserved_a:
        assert property (RD_VALID && $past(REQ.addr) == 7'h05 |-> (RD_DATA & 8'hdc) == 8'h00)
        else $error("reserved bits read nonzero");
    no_fail_flag_a: assert property (!ACCESS_FAIL)
        else $error("access failure flag raised");
    swk_hold_a: assert property (swk_hist_reg == 3'h0 |-> $stable(XCVR_CTRL.selective_wake))
        else $error("selective wake changed without a host write");
    sleep_wake_a:
        assert property (sleep_in && (can == 2'h2 || (can == 2'h3 && !SYSTEM_ERROR_FLAG)) |-> ##[2:3] can == 2'h1)
        else $error("CAN not wake capable after sleep entry");
    stop_keep_a: assert property (stop_in && can == 2'h2 |-> ##2 can == 2'h2 ##1 can == 2'h2)
        else $error("CAN receive only lost on stop entry");
    lp_keep_a: assert property ((sleep_in || stop_in) && !can[1] |-> ##2 $stable(can) [*2])
        else $error("CAN off or wake mode changed on low-power entry");
    fail_safe_a: assert property (fs_ev |-> ##[2:3] XCVR_CTRL[7:0] == 8'h4a)
        else $error("fail-safe values not forced");
    peak_lock_a:
        assert property (REQ_VALID && REQ.wr && REQ.addr == 7'h05 && CHIP_MODE == bus_mode_pkg::CHIP_STOP
            |-> ##2 $stable(XCVR_CTRL.regulator_peak_threshold_sel) [*2])
        else $error("peak threshold changed in stop mode");
    // Main scenarios reached
    cover property (sleep_in);
    cover property (fs_ev);
    cover property (REQ_VALID && REQ.wr && CHIP_MODE == bus_mode_pkg::CHIP_STOP);
endmodule : bus_mode_monitor

bind bus_transceiver_mode_control bus_mode_monitor i_bus_mode_monitor (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .REQ_VALID(REQ_VALID), .REQ(REQ), .CHIP_MODE(CHIP_MODE),
    .FAILURE_ENTRY(FAILURE_ENTRY), .SYSTEM_ERROR_FLAG(SYSTEM_ERROR_FLAG), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .ACCESS_FAIL(ACCESS_FAIL), .XCVR_CTRL(XCVR_CTRL));

// File: bus_mode_pkg.sv
/*
 * Types shared by the bus mode control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bus_mode_pkg;

    // Two-bit transceiver mode code
    typedef enum logic [1:0] {
        XCVR_OFF = 2'h0,
        XCVR_WAKE = 2'h1,
        XCVR_RX_ONLY = 2'h2,
        XCVR_NORMAL = 2'h3
    } xcvr_mode_t;

    // Chip operating mode reported by the mode state machine
    typedef enum logic [2:0] {
        CHIP_INIT = 3'h0,
        CHIP_NORMAL = 3'h1,
        CHIP_STOP = 3'h2,
        CHIP_SLEEP = 3'h3,
        CHIP_RESTART = 3'h4,
        CHIP_FAILSAFE = 3'h5
    } chip_mode_t;

    // One serial write or read request as decoded by the frame logic
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_req_t;

    // Transceiver controls handed to the analog front ends
    typedef struct packed {
        logic flash_mode;
        logic low_slope_select;
        logic tx_timeout_enable;
        xcvr_mode_t first_lin_mode;
        logic selective_wake;
        xcvr_mode_t can_mode;
        xcvr_mode_t second_lin_mode;
        logic regulator_peak_threshold_sel;
    } xcvr_ctrl_t;

endpackage : bus_mode_pkg

// File: bus_mode_regs.svh
/*
 * Offsets, field positions, reset and forced values of the two bus mode control registers.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef BUS_MODE_REGS_SVH
`define BUS_MODE_REGS_SVH

// Register addresses on the 7-bit serial address field
`define BUS_PRIMARY_ADDR 7'h04
`define BUS_SECONDARY_ADDR 7'h05

// Primary register fields
`define PRI_FLASH_BIT 7
`define PRI_LOW_SLOPE_BIT 6
`define PRI_TX_TIMEOUT_BIT 5
`define PRI_FIRST_LIN_MODE_MSB 4
`define PRI_FIRST_LIN_MODE_LSB 3
`define PRI_SWK_BIT 2
`define PRI_CAN_MSB 1
`define PRI_CAN_LSB 0

// Secondary register fields
`define SEC_PEAK_BIT 5
`define SEC_SECOND_LIN_MODE_MSB 1
`define SEC_SECOND_LIN_MODE_LSB 0
`define SEC_WRITE_MASK 8'h23

// Reset and fail-safe values
`define PRI_RESET_VAL 8'h20
`define SEC_RESET_VAL 8'h00
`define PRI_FAILSAFE_LOW 5'h09
`define SEC_FAILSAFE_VAL 8'h01

`endif

// File: bus_transceiver_mode_control.sv
/*
 * Bus transceiver mode control: two serial-written control registers selecting CAN and LIN
 * transceiver modes, LIN slope options and the main regulator peak threshold, plus the
 * automatic mode changes on Sleep, Stop and failure-driven Fail-Safe entry.
 * Assumes a serial frame decoder on CORE_CLK that presents one decoded request per frame
 * together with the chip select level, and a chip mode state machine on the same clock.
 */
// How it works
// - Primary bit 7 high turns LIN slope control off for fast flashing.
// - Primary bit 6 high selects LIN low-slope operation.
// - Primary bit 5 enables the LIN transmit time-out.
// - Primary bits 4:3 set first LIN mode off, wake, receive, normal.
// - Primary bits 2:0 set CAN mode; bit 2 adds selective wake.
// - Flash and low-slope changes apply when chip select returns high.
// - Only host writes and failure Fail-Safe entry change the selective-wake bit.
// - Sleep entry without system error turns CAN normal into wake capable.
// - CAN receive-only goes wake capable on Sleep, stays on Stop.
// - CAN wake capable or off stays unchanged on low-power entry.
// - Failure Fail-Safe entry forces primary low five bits to 0 1001.
// - Failure Fail-Safe entry forces secondary register to 0000 0001.
// - Secondary bit 5 selects low or high regulator peak threshold.
// - Peak threshold is writable in Init and Normal, not Stop.
// - Stop-mode peak write raises no access failure nor interrupt.
// - Secondary bits 1:0 set second LIN mode.
// - Secondary reserved bits always read zero.
`timescale 1ns/100ps
`include "bus_mode_regs.svh"

module bus_transceiver_mode_control (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SRST,
    // Serial frame side
    input wire logic SERIAL_CHIP_SELECT,
    input wire logic REQ_VALID,
    input wire bus_mode_pkg::reg_req_t REQ,
    // Chip state
    input wire bus_mode_pkg::chip_mode_t CHIP_MODE,
    input wire logic FAILURE_ENTRY,
    input wire logic SYSTEM_ERROR_FLAG,
    // Register read back
    output logic [7:0] RD_DATA,
    output logic RD_VALID,
    output logic ACCESS_FAIL,
    // Transceiver controls
    output bus_mode_pkg::xcvr_ctrl_t XCVR_CTRL
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Behaviour in brief
    //
    // Host writes land at the edge that takes the request. The transceiver controls follow
    // one edge later, so the analog side never sees a half-written byte.
    // The two slope bits are the exception. They wait for the end of the frame, because a
    // slope change in the middle of a LIN frame would distort the bits on the wire.
    // Sleep and Stop entry events last one cycle, Fail-Safe entry as long as the failure input is high. They win over a host write
    // of the same bits in that cycle, and the host can always write again afterwards.
    // The block never flags an access failure. A peak threshold write in Stop is dropped
    // silently, and the host can only notice that by reading the register back.
    // Restart behaviour belongs to the mode state machine, and nothing here reacts to it.
    // Limitation: a level on the failure input keeps forcing the wake values while it stays
    // high, so host writes to the forced fields are lost until it drops.

    ////////////////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // True when a write request targets the given address
    function automatic logic wr_hit(input bus_mode_pkg::reg_req_t r, input logic [6:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    // Automatic CAN low-bit change on entry to a low-power mode
    function automatic logic [1:0] can_low_power(input logic [1:0] cur, input logic to_sleep,
                                                 input logic system_error_flag);
        can_low_power = cur;
        if (to_sleep && (cur == bus_mode_pkg::XCVR_RX_ONLY)) begin
            can_low_power = bus_mode_pkg::XCVR_WAKE;
        end
        if (to_sleep && !system_error_flag && (cur == bus_mode_pkg::XCVR_NORMAL)) begin
            can_low_power = bus_mode_pkg::XCVR_WAKE;
        end
    endfunction : can_low_power

    // True when a read request targets the given address
    function automatic logic rd_hit(input bus_mode_pkg::reg_req_t r, input logic [6:0] a);
        rd_hit = !r.wr && (r.addr == a);
    endfunction : rd_hit

    // True for either address this block answers; all others stay silent
    function automatic logic mapped(input logic [6:0] a);
        mapped = (a == `BUS_PRIMARY_ADDR) || (a == `BUS_SECONDARY_ADDR);
    endfunction : mapped

    // Two-bit mode field of a register as the enumerated transceiver mode
    function automatic bus_mode_pkg::xcvr_mode_t mode_of(input logic [1:0] f);
        mode_of = bus_mode_pkg::xcvr_mode_t'(f);
    endfunction : mode_of

    ////////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation of the chip select pin

    localparam int SYNC_STAGES = 3;

    // Stage 0 faces the pin and only stage 1 reads it, so a metastable value never fans out
    logic [SYNC_STAGES-1:0] cs_sync_reg;
    logic cs_stage2;
    logic cs_stage3;
    logic cs_level_reg;

    // Shift chain preset high, so reset looks like a deselected frame and no false rise follows
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cs_sync_reg <= '1;
        end else begin
            cs_sync_reg <= {cs_sync_reg[SYNC_STAGES-2:0], SERIAL_CHIP_SELECT};
        end
    end

    assign cs_stage2 = cs_sync_reg[1];
    assign cs_stage3 = cs_sync_reg[2];

    // Level only moves once stages two and three agree, which filters a one-cycle glitch
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            cs_level_reg <= 1'b1;
        end else if (cs_stage2 == cs_stage3) begin
            cs_level_reg <= cs_stage3;
        end
    end

    // One-cycle strobe on the agreed low-to-high step of the chip select
    logic cs_rise;
    assign cs_rise = cs_stage2 && cs_stage3 && !cs_level_reg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Mode entry detection

    bus_mode_pkg::chip_mode_t mode_prev_reg;

    // Remember last mode so a mode entry is seen once
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            mode_prev_reg <= bus_mode_pkg::CHIP_INIT;
        end else begin
            mode_prev_reg <= CHIP_MODE;
        end
    end

    // Sleep and stop strobes last one cycle, so holding the mode acts only once; fail-safe entry lasts while the failure input is high
    logic enter_sleep;
    logic enter_stop;
    logic enter_failsafe;
    assign enter_sleep = (CHIP_MODE == bus_mode_pkg::CHIP_SLEEP) && (mode_prev_reg != bus_mode_pkg::CHIP_SLEEP);
    assign enter_stop = (CHIP_MODE == bus_mode_pkg::CHIP_STOP) && (mode_prev_reg != bus_mode_pkg::CHIP_STOP);
    assign enter_failsafe = FAILURE_ENTRY && (CHIP_MODE == bus_mode_pkg::CHIP_FAILSAFE);

    // Host write strobes, one for each register
    logic wr_pri;
    logic wr_sec;
    assign wr_pri = REQ_VALID && wr_hit(REQ, `BUS_PRIMARY_ADDR);
    assign wr_sec = REQ_VALID && wr_hit(REQ, `BUS_SECONDARY_ADDR);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Primary register

    logic [7:0] pri_reg;
    logic [7:0] pri_next;

    // Hardware events win over a host write in the same cycle, so a forced wake setting
    // cannot be lost to a late frame.
    always_comb begin
        pri_next = pri_reg;
        if (wr_pri) begin
            pri_next = REQ.data;
        end
        if (enter_failsafe) begin
            pri_next[4:0] = `PRI_FAILSAFE_LOW;
        end else if (enter_sleep || enter_stop) begin
            // Selective-wake bit is never touched here
            pri_next[`PRI_CAN_MSB:`PRI_CAN_LSB] = can_low_power(pri_reg[`PRI_CAN_MSB:`PRI_CAN_LSB],
                                                                 enter_sleep, SYSTEM_ERROR_FLAG);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pri_reg <= `PRI_RESET_VAL;
        end else begin
            pri_reg <= pri_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Secondary register

    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic peak_locked;
    assign peak_locked = (CHIP_MODE == bus_mode_pkg::CHIP_STOP);

    // Peak bit frozen in Stop; write of other fields still lands
    always_comb begin
        sec_next = sec_reg;
        if (wr_sec) begin
            sec_next = REQ.data & `SEC_WRITE_MASK;
            if (peak_locked) begin
                sec_next[`SEC_PEAK_BIT] = sec_reg[`SEC_PEAK_BIT];
            end
        end
        if (enter_failsafe) begin
            sec_next = `SEC_FAILSAFE_VAL;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            sec_reg <= `SEC_RESET_VAL;
        end else begin
            sec_reg <= sec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Slope options held until chip select returns high

    logic flash_reg;
    logic low_slope_reg;

    // Shadow copies avoid slope glitches while a frame is still in flight
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            flash_reg <= 1'b0;
            low_slope_reg <= 1'b0;
        end else if (cs_rise) begin
            flash_reg <= pri_reg[`PRI_FLASH_BIT];
            low_slope_reg <= pri_reg[`PRI_LOW_SLOPE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read back and status

    // Read strobes, decoded once and shared by the two read processes
    logic rd_any;
    logic rd_pri;
    logic rd_sec;
    assign rd_pri = REQ_VALID && rd_hit(REQ, `BUS_PRIMARY_ADDR);
    assign rd_sec = REQ_VALID && rd_hit(REQ, `BUS_SECONDARY_ADDR);
    assign rd_any = REQ_VALID && !REQ.wr && mapped(REQ.addr);

    // Valid only for the two mapped addresses; any other read goes unanswered
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= rd_any;
        end
    end

    // Read data reflects stored state including hardware changes; it idles at zero
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            RD_DATA <= 8'h00;
        end else if (rd_pri) begin
            RD_DATA <= pri_reg;
        end else if (rd_sec) begin
            RD_DATA <= sec_reg & `SEC_WRITE_MASK;
        end else begin
            RD_DATA <= 8'h00;
        end
    end

    // No access failure from this block; a locked peak write is silently dropped
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ACCESS_FAIL <= 1'b0;
        end else begin
            ACCESS_FAIL <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Transceiver control outputs
    //
    // One process for each group of controls. Every bit is a flip-flop, so the analog front
    // ends see clean levels, at the cost of one cycle of latency after the register.

    logic out_flash_reg;
    logic out_low_slope_reg;
    logic out_tx_timeout_reg;
    bus_mode_pkg::xcvr_mode_t out_first_lin_mode_reg;
    bus_mode_pkg::xcvr_mode_t out_second_lin_mode_reg;
    logic out_swk_reg;
    bus_mode_pkg::xcvr_mode_t out_can_reg;
    logic out_peak_reg;

    // LIN slope options, taken from the end-of-frame copies
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            out_flash_reg <= 1'b0;
            out_low_slope_reg <= 1'b0;
        end else begin
            out_flash_reg <= flash_reg;
            out_low_slope_reg <= low_slope_reg;
        end
    end

    // LIN transmit time-out and both LIN transceiver modes
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            out_tx_timeout_reg <= 1'b1;
            out_first_lin_mode_reg <= bus_mode_pkg::XCVR_OFF;
            out_second_lin_mode_reg <= bus_mode_pkg::XCVR_OFF;
        end else begin
            out_tx_timeout_reg <= pri_reg[`PRI_TX_TIMEOUT_BIT];
            out_first_lin_mode_reg <= mode_of(pri_reg[`PRI_FIRST_LIN_MODE_MSB:`PRI_FIRST_LIN_MODE_LSB]);
            out_second_lin_mode_reg <= mode_of(sec_reg[`SEC_SECOND_LIN_MODE_MSB:`SEC_SECOND_LIN_MODE_LSB]);
        end
    end

    // CAN mode and its selective-wake qualifier
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            out_swk_reg <= 1'b0;
            out_can_reg <= bus_mode_pkg::XCVR_OFF;
        end else begin
            out_swk_reg <= pri_reg[`PRI_SWK_BIT];
            out_can_reg <= mode_of(pri_reg[`PRI_CAN_MSB:`PRI_CAN_LSB]);
        end
    end

    // Main regulator peak threshold select
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            out_peak_reg <= 1'b0;
        end else begin
            out_peak_reg <= sec_reg[`SEC_PEAK_BIT];
        end
    end

    // Pure wiring of the flip-flops into the output carrier, in its field order
    assign XCVR_CTRL = {out_flash_reg, out_low_slope_reg, out_tx_timeout_reg, out_first_lin_mode_reg,
                        out_swk_reg, out_can_reg, out_second_lin_mode_reg, out_peak_reg};

endmodule : bus_transceiver_mode_control

// File: host_model.sv
/* Host model: serial master issuing one decoded request per frame.
   Assumes the bench calls access from a single process. */
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic clk,
    // Read back
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // Frame side
    output logic serial_chip_select_n,
    output logic req_valid,
    output bus_mode_pkg::reg_req_t req
);
    // Idle frame lines from time zero
    initial begin
        serial_chip_select_n = 1'b1;
        req_valid = 1'b0;
        req = '0;
    end
    ////////////////////////////////////////
    // One frame: select, one request pulse, answer one edge later, deselect
    task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, input logic slow,
                          output logic [7:0] q, output logic ok);
        @(posedge clk);
        serial_chip_select_n <= 1'b0;
        req_valid <= 1'b1;
        req <= {wr, a, d};
        @(posedge clk);
        req_valid <= 1'b0;
        req <= ~{wr, a, d}; // Released lines must not keep the last value
        @(posedge clk);
        q = rd_data;
        ok = rd_valid;
        if (slow) begin
            repeat (3) @(posedge clk);
        end
        serial_chip_select_n <= 1'b1;
    endtask : access
endmodule : host_model

// File: testbench.sv
/* Self-checking bench of the bus mode control block.
   Assumes the host model issues the serial requests. */
`timescale 1ns/100ps
module testbench;
    logic CORE_CLK;
    logic SRST;
    bus_mode_pkg::chip_mode_t chip_mode;
    logic failure_entry;
    logic sys_err;
    logic cs_n;
    logic req_valid;
    bus_mode_pkg::reg_req_t req;
    logic [7:0] rd_data;
    logic rd_valid;
    logic access_fail;
    bus_mode_pkg::xcvr_ctrl_t xcvr;
    logic [15:0] lfsr = 16'h8951;
    int miscompares = 0;
    int tests_run = 0;
    logic [7:0] q;
    logic ok;
    logic [7:0] pri;
    logic [7:0] sec;

    bus_transceiver_mode_control i_bus_transceiver_mode_control (.CORE_CLK(CORE_CLK), .SRST(SRST),
        .SERIAL_CHIP_SELECT(cs_n), .REQ_VALID(req_valid), .REQ(req), .CHIP_MODE(chip_mode),
        .FAILURE_ENTRY(failure_entry), .SYSTEM_ERROR_FLAG(sys_err), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .ACCESS_FAIL(access_fail), .XCVR_CTRL(xcvr));
    host_model i_host_model (.clk(CORE_CLK), .rd_data(rd_data), .rd_valid(rd_valid),
        .serial_chip_select_n(cs_n), .req_valid(req_valid), .req(req));
    ////////////////////////////////////////
    // Clock at 250 MHz
    initial begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    // Pseudo-random bytes, repeatable run to run
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    // Expected controls from the two register values
    function automatic logic [10:0] exp_ctrl(input logic [7:0] p, input logic [7:0] s);
        return {p, s[1:0], s[5]};
    endfunction : exp_ctrl
    // Expected primary after a sleep or stop entry
    function automatic logic [7:0] exp_lp(input logic [7:0] p, input logic sleep, input logic err);
        if (sleep && (p[1:0] == 2'h2 || (p[1:0] == 2'h3 && !err))) begin
            return {p[7:2], 2'h1};
        end
        return p;
    endfunction : exp_lp
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // One frame, then room for the chip select synchroniser to settle
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
        i_host_model.access(wr, a, d, lfsr[0], q, ok);
        repeat (8) @(posedge CORE_CLK);
    endtask : xfer
    task automatic go(input bus_mode_pkg::chip_mode_t m);
        @(posedge CORE_CLK);
        chip_mode <= m;
        repeat (4) @(posedge CORE_CLK);
    endtask : go
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Hang guard
    initial begin
        repeat (100000) @(posedge CORE_CLK);
        miscompares++;
        final_report();
    end
    ////////////////////////////////////////
    initial begin
        SRST = 1'b1;
        chip_mode = bus_mode_pkg::CHIP_INIT;
        failure_entry = 1'b0;
        sys_err = 1'b0;
        repeat (6) @(posedge CORE_CLK);
        SRST <= 1'b0;
        xfer(1'b0, 7'h04, 8'h00);
        check(q, 8'h20);
        xfer(1'b0, 7'h05, 8'hff);
        check(q, 8'h00);
        check(xcvr, exp_ctrl(8'h20, 8'h00));
        xfer(1'b0, 7'h06, 8'h00);
        check(ok, 1'b0);
        $display("test reset done");
        // Random settings, first in init, then in normal mode
        for (int i = 0; i < 24; i++) begin
            pri = rnd();
            sec = (i == 0) ? 8'hff : rnd();
            if (i == 12) begin
                go(bus_mode_pkg::CHIP_NORMAL);
            end
            xfer(1'b1, 7'h04, pri);
            xfer(1'b1, 7'h05, sec);
            xfer(1'b0, 7'h04, 8'h00);
            check(q, pri);
            xfer(1'b0, 7'h05, 8'h00);
            check(q, sec & 8'h23);
            check(xcvr, exp_ctrl(pri, sec));
        end
        $display("test settings done");
        // Peak threshold locked in stop mode
        go(bus_mode_pkg::CHIP_STOP);
        xfer(1'b1, 7'h05, ~sec);
        xfer(1'b0, 7'h05, 8'h00);
        check(q, {2'h0, sec[5], 3'h0, ~sec[1:0]});
        check(access_fail, 1'b0);
        $display("test peak lock done");
        // Every CAN mode into sleep and stop, with and without system error
        for (int i = 0; i < 16; i++) begin
            go(bus_mode_pkg::CHIP_NORMAL);
            sys_err <= i[3];
            pri = rnd();
            pri[1:0] = i[1:0];
            xfer(1'b1, 7'h04, pri);
            go(i[2] ? bus_mode_pkg::CHIP_SLEEP : bus_mode_pkg::CHIP_STOP);
            xfer(1'b0, 7'h04, 8'h00);
            check(q, exp_lp(pri, i[2], i[3]));
        end
        $display("test low power done");
        // Failure-driven fail-safe entry
        go(bus_mode_pkg::CHIP_FAILSAFE);
        failure_entry <= 1'b1;
        @(posedge CORE_CLK);
        failure_entry <= 1'b0;
        xfer(1'b0, 7'h04, 8'h00);
        check(q, {pri[7:5], 5'h09});
        xfer(1'b0, 7'h05, 8'h00);
        check(q, 8'h01);
        $display("test fail-safe done");
        final_report();
    end
endmodule : testbench
